// >>> disk_status_pkg.sv
// Constants, bit layout and command kinds for the result-status flag block.
// Assumes a single 10 MHz controller clock; all counts derive from CLK_PERIOD_NS.
//
// Behaviour
// - Write-protect during write-class commands sets not-writable
// - Two index pulses without ID mark: absent-header
// - Missing data mark sets absent-header and absent-data
// - Second error register top bit reads zero
// - Deleted mark during read/scan sets deleted-record
// - Data field CRC mismatch sets data-crc flag
// - Cylinder mismatch with no-sector sets wrong-cylinder
// - Mismatch with cylinder all ones and no-sector sets bad-cylinder
// - Scan equality met sets scan-equal
// - Scan with no matching sector sets scan-fail
// - Missing data mark on read sets absent-data
// - Drive status top bit mirrors fault input
// - Drive status shows write-protect, ready, two-side
// - Drive status bit four mirrors track-zero
// - Drive status shows driven side select
// - Two low bits show driven unit selects
// - Same-unit step interval programmable 1..16 ms
// - Steps to different units spaced 33 us
// - Half-rate clock doubles every interval
// - Unfound target sector on read, write-deleted or scan sets no-sector flag
package disk_status_pkg;

  // Timing base
  localparam int CLK_PERIOD_NS      = 100;
  localparam int MS_TIME_NS         = 1000000;
  localparam int MS_CYCLES_C        = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UNIT_GAP_NS        = 33000;
  localparam int GAP_CYCLES_C       = (UNIT_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_HIGH_NS       = 5000;
  localparam int STEP_HIGH_CYCLES_C = (STEP_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOW_FACTOR        = 2;
  localparam int MS_W               = 16;

  localparam logic [9:0] GAP_LOAD       = 10'(GAP_CYCLES_C);
  localparam logic [9:0] GAP_LOAD_SLOW  = 10'(GAP_CYCLES_C * SLOW_FACTOR);
  localparam logic [7:0] HIGH_LOAD      = 8'(STEP_HIGH_CYCLES_C);
  localparam logic [7:0] HIGH_LOAD_SLOW = 8'(STEP_HIGH_CYCLES_C * SLOW_FACTOR);
  // Rate code F means 1 ms, 0 means 16 ms; one extra tick guards the phase of the ms divider
  localparam logic [4:0] RATE_BASE      = 5'h11;

  // Result byte selects on the data port
  localparam logic [1:0] REG_ONE   = 2'h1;
  localparam logic [1:0] REG_TWO   = 2'h2;
  localparam logic [1:0] REG_THREE = 2'h3;

  localparam logic [7:0] CYL_ALL_ONES = 8'hff;
  localparam logic [1:0] INDEX_LIMIT  = 2'h2;
  localparam logic [7:0] STATUS_RST   = 8'h00;

  // Error register one
  localparam int ST1_NO_SECTOR     = 2;
  localparam int ST1_NOT_WRITABLE  = 1;
  localparam int ST1_ABSENT_HEADER = 0;
  // Error register two
  localparam int ST2_UNUSED        = 7;
  localparam int ST2_DELETED       = 6;
  localparam int ST2_DATA_CRC      = 5;
  localparam int ST2_WRONG_CYL     = 4;
  localparam int ST2_SCAN_EQUAL    = 3;
  localparam int ST2_SCAN_FAIL     = 2;
  localparam int ST2_BAD_CYL       = 1;
  localparam int ST2_ABSENT_DATA   = 0;
  // Drive line register
  localparam int ST3_FAULT         = 7;
  localparam int ST3_WRITE_PROT    = 6;
  localparam int ST3_READY         = 5;
  localparam int ST3_TRACK_ZERO    = 4;
  localparam int ST3_TWO_SIDED     = 3;
  localparam int ST3_HEAD          = 2;
  localparam int ST3_SEL_HIGH      = 1;
  localparam int ST3_SEL_LOW       = 0;

  // Synchroniser lanes
  localparam int PIN_FAULT = 0;
  localparam int PIN_WP    = 1;
  localparam int PIN_READY = 2;
  localparam int PIN_TRK0  = 3;
  localparam int PIN_TWO   = 4;
  localparam int PIN_INDEX = 5;

  typedef enum logic [2:0] {
    CMD_READ, CMD_READ_DELETED, CMD_WRITE, CMD_WRITE_DELETED,
    CMD_FORMAT, CMD_SCAN, CMD_READ_ID, CMD_OTHER
  } cmd_kind_t;

  function automatic logic is_write_class(cmd_kind_t k);
    return (k == CMD_WRITE) || (k == CMD_WRITE_DELETED) || (k == CMD_FORMAT);
  endfunction

  function automatic logic is_read_or_scan(cmd_kind_t k);
    return (k == CMD_READ) || (k == CMD_SCAN);
  endfunction

  function automatic logic is_sector_search(cmd_kind_t k);
    return (k == CMD_READ) || (k == CMD_WRITE_DELETED) || (k == CMD_SCAN);
  endfunction

endpackage

// >>> step_pacer.sv
// Step pacing: grants a step request only when the unit's own interval and the
// cross-unit gap have both run out. Assumes a one-cycle ms_tick from the caller.
`timescale 1ns/100ps
module step_pacer
  import disk_status_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ms_tick,
  input  wire logic       step_req,
  input  wire logic [1:0] step_unit,
  input  wire logic [3:0] step_rate,
  input  wire logic       half_rate,
  output logic            step_grant
);

  typedef struct packed {
    logic [3:0][4:0] unit_ms;
    logic [9:0]      gap_cnt;
  } pacer_t;

  pacer_t st_ff;
  pacer_t nxt_st;

  // Countdowns and grant; ms_tick already runs at half speed in half-rate mode
  always_comb begin
    nxt_st     = st_ff;
    step_grant = step_req && (st_ff.unit_ms[step_unit] == 5'h00) && (st_ff.gap_cnt == 10'h000);
    for (int i = 0; i < 4; i++) begin
      if (ms_tick && (st_ff.unit_ms[i] != 5'h00)) begin
        nxt_st.unit_ms[i] = st_ff.unit_ms[i] - 5'h01;
      end
    end
    if (st_ff.gap_cnt != 10'h000) begin
      nxt_st.gap_cnt = st_ff.gap_cnt - 10'h001;
    end
    if (step_grant) begin
      nxt_st.unit_ms[step_unit] = RATE_BASE - {1'b0, step_rate};
      nxt_st.gap_cnt            = half_rate ? GAP_LOAD_SLOW : GAP_LOAD;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_gap_blocks_step: assert property (st_ff.gap_cnt != 10'h000 |-> !step_grant)
    else $error("step granted inside cross-unit gap");
  a_gap_full_rate: assert property (step_grant && !half_rate |=> st_ff.gap_cnt == 10'd330)
    else $error("cross-unit gap not loaded with 330 cycles");
  a_gap_doubled: assert property (step_grant && half_rate |=> st_ff.gap_cnt == 10'd660)
    else $error("half-rate gap not doubled");
  a_unit_interval: assert property (step_grant |=> st_ff.unit_ms[$past(step_unit)] == 5'd17 - {1'b0, $past(step_rate)})
    else $error("unit interval not loaded from rate code");

endmodule

// >>> disk_ctrl_result_status_flags.sv
// Result-status flags and drive line status of the disk controller.
// Assumes the command sequencer drives the event strobes on clk; drive pins are asynchronous.
`timescale 1ns/100ps
module disk_ctrl_result_status_flags
  import disk_status_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_C
)
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       fault_pin,
  input  wire logic       write_protect_pin,
  input  wire logic       ready_pin,
  input  wire logic       track_zero_pin,
  input  wire logic       two_side_pin,
  input  wire logic       index_pin,
  input  wire logic       cmd_start,
  input  wire cmd_kind_t  cmd_kind,
  input  wire logic       cmd_done,
  input  wire logic       id_search,
  input  wire logic       id_found,
  input  wire logic       id_check,
  input  wire logic [7:0] cyl_read,
  input  wire logic [7:0] target_id_fields,
  input  wire logic       data_mark_miss,
  input  wire logic       deleted_mark_seen,
  input  wire logic       data_crc_err,
  input  wire logic       sector_not_found,
  input  wire logic       scan_equal_hit,
  input  wire logic       scan_no_match,
  input  wire logic       head_req,
  input  wire logic [1:0] unit_req,
  input  wire logic       step_req,
  input  wire logic [3:0] step_rate,
  input  wire logic       half_rate,
  input  wire logic       rd_strobe,
  input  wire logic [1:0] rd_sel,
  output logic            head_side,
  output logic [1:0]      drive_sel,
  output logic            step_pulse,
  output logic [7:0]      rd_data,
  output logic            rd_valid
);

  typedef struct packed {
    logic [5:0]      sync1;
    logic [5:0]      sync2;
    logic            idx_prev;
    logic [1:0]      idx_count;
    logic            cmd_active;
    cmd_kind_t       kind;
    logic            cyl_mismatch;
    logic            cyl_all_ones;
    logic            no_sector_flag;
    logic            not_writable_flag;
    logic            absent_header_flag;
    logic            deleted_record_flag;
    logic            data_crc_flag;
    logic            wrong_cylinder_flag;
    logic            scan_equal_flag;
    logic            scan_fail_flag;
    logic            bad_cylinder_flag;
    logic            absent_data_flag;
    logic            head_side_bit;
    logic            drive_sel_high_bit;
    logic            drive_sel_low_bit;
    logic [MS_W-1:0] ms_cnt;
    logic            ms_tick;
    logic [7:0]      high_cnt;
    logic            step_out;
    logic [7:0]      rd_byte;
    logic            rd_ok;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  logic       step_grant;
  logic       in_cmd;
  cmd_kind_t  kind_now;
  logic       idx_rise;
  logic [7:0] err_one;
  logic [7:0] err_two;
  logic [7:0] drive_lines;

  // Result bytes assembled from the flag flops; unused bits stay low
  always_comb begin
    err_one                    = STATUS_RST;
    err_one[ST1_NO_SECTOR]     = st_ff.no_sector_flag;
    err_one[ST1_NOT_WRITABLE]  = st_ff.not_writable_flag;
    err_one[ST1_ABSENT_HEADER] = st_ff.absent_header_flag;

    err_two                    = STATUS_RST;
    err_two[ST2_UNUSED]        = 1'b0;
    err_two[ST2_DELETED]       = st_ff.deleted_record_flag;
    err_two[ST2_DATA_CRC]      = st_ff.data_crc_flag;
    err_two[ST2_WRONG_CYL]     = st_ff.wrong_cylinder_flag;
    err_two[ST2_SCAN_EQUAL]    = st_ff.scan_equal_flag;
    err_two[ST2_SCAN_FAIL]     = st_ff.scan_fail_flag;
    err_two[ST2_BAD_CYL]       = st_ff.bad_cylinder_flag;
    err_two[ST2_ABSENT_DATA]   = st_ff.absent_data_flag;

    // Pins are shown after synchronisation, so a read lags the pin by two cycles
    drive_lines                 = STATUS_RST;
    drive_lines[ST3_FAULT]      = st_ff.sync2[PIN_FAULT];
    drive_lines[ST3_WRITE_PROT] = st_ff.sync2[PIN_WP];
    drive_lines[ST3_READY]      = st_ff.sync2[PIN_READY];
    drive_lines[ST3_TRACK_ZERO] = st_ff.sync2[PIN_TRK0];
    drive_lines[ST3_TWO_SIDED]  = st_ff.sync2[PIN_TWO];
    drive_lines[ST3_HEAD]       = st_ff.head_side_bit;
    drive_lines[ST3_SEL_HIGH]   = st_ff.drive_sel_high_bit;
    drive_lines[ST3_SEL_LOW]    = st_ff.drive_sel_low_bit;
  end

  // Next-state logic for the whole block
  always_comb begin
    nxt_st   = st_ff;
    in_cmd   = st_ff.cmd_active | cmd_start;
    kind_now = cmd_start ? cmd_kind : st_ff.kind;

    // Pin synchronisers; only the second stage is read below
    nxt_st.sync1    = {index_pin, two_side_pin, track_zero_pin, ready_pin, write_protect_pin, fault_pin};
    nxt_st.sync2    = st_ff.sync1;
    nxt_st.idx_prev = st_ff.sync2[PIN_INDEX];
    idx_rise        = st_ff.sync2[PIN_INDEX] & ~st_ff.idx_prev;

    // Command framing: clear first, so an event in the start cycle still lands
    if (cmd_start) begin
      nxt_st.cmd_active          = 1'b1;
      nxt_st.kind                = cmd_kind;
      nxt_st.cyl_mismatch        = 1'b0;
      nxt_st.cyl_all_ones        = 1'b0;
      nxt_st.idx_count           = 2'h0;
      nxt_st.no_sector_flag      = 1'b0;
      nxt_st.not_writable_flag   = 1'b0;
      nxt_st.absent_header_flag  = 1'b0;
      nxt_st.deleted_record_flag = 1'b0;
      nxt_st.data_crc_flag       = 1'b0;
      nxt_st.wrong_cylinder_flag = 1'b0;
      nxt_st.scan_equal_flag     = 1'b0;
      nxt_st.scan_fail_flag      = 1'b0;
      nxt_st.bad_cylinder_flag   = 1'b0;
      nxt_st.absent_data_flag    = 1'b0;
    end else if (cmd_done) begin
      nxt_st.cmd_active = 1'b0;
    end

    // Write protection is a level: checked every cycle of a write-class command
    if (in_cmd && is_write_class(kind_now) && st_ff.sync2[PIN_WP]) begin
      nxt_st.not_writable_flag = 1'b1;
    end

    // Index revolutions counted while the sequencer hunts for an ID mark
    if (!id_search || id_found) begin
      nxt_st.idx_count = 2'h0;
    end else if (idx_rise && (st_ff.idx_count != INDEX_LIMIT)) begin
      nxt_st.idx_count = st_ff.idx_count + 2'h1;
      if (in_cmd && (st_ff.idx_count == INDEX_LIMIT - 2'h1)) begin
        nxt_st.absent_header_flag = 1'b1;
      end
    end

    // Missing data mark raises both registers in the same cycle
    if (in_cmd && data_mark_miss) begin
      nxt_st.absent_header_flag = 1'b1;
      nxt_st.absent_data_flag   = 1'b1;
    end

    if (in_cmd && deleted_mark_seen && is_read_or_scan(kind_now)) begin
      nxt_st.deleted_record_flag = 1'b1;
    end

    if (in_cmd && data_crc_err) begin
      nxt_st.data_crc_flag = 1'b1;
    end

    // Header cylinder compare, remembered until the next command start
    if (in_cmd && id_check && (cyl_read != target_id_fields)) begin
      nxt_st.cyl_mismatch = 1'b1;
      if (cyl_read == CYL_ALL_ONES) begin
        nxt_st.cyl_all_ones = 1'b1;
      end
    end

    // Cylinder flags only travel with the no-sector condition
    if (in_cmd && sector_not_found && is_sector_search(kind_now)) begin
      nxt_st.no_sector_flag = 1'b1;
      if (st_ff.cyl_mismatch) begin
        nxt_st.wrong_cylinder_flag = 1'b1;
      end
      if (st_ff.cyl_mismatch && st_ff.cyl_all_ones) begin
        nxt_st.bad_cylinder_flag = 1'b1;
      end
    end

    if (in_cmd && (kind_now == CMD_SCAN) && scan_equal_hit) begin
      nxt_st.scan_equal_flag = 1'b1;
    end
    if (in_cmd && (kind_now == CMD_SCAN) && scan_no_match) begin
      nxt_st.scan_fail_flag = 1'b1;
    end

    // Millisecond enable; half-rate stretches it so every ms interval doubles
    if (st_ff.ms_cnt >= (half_rate ? MS_W'(MS_CYCLES * SLOW_FACTOR - 1) : MS_W'(MS_CYCLES - 1))) begin
      nxt_st.ms_cnt  = '0;
      nxt_st.ms_tick = 1'b1;
    end else begin
      nxt_st.ms_cnt  = st_ff.ms_cnt + MS_W'(1);
      nxt_st.ms_tick = 1'b0;
    end

    // Step pulse stretched to its active width once the pacer grants it
    if (step_grant) begin
      nxt_st.high_cnt = half_rate ? HIGH_LOAD_SLOW : HIGH_LOAD;
    end else if (st_ff.high_cnt != 8'h00) begin
      nxt_st.high_cnt = st_ff.high_cnt - 8'h01;
    end
    nxt_st.step_out = (nxt_st.high_cnt != 8'h00);

    // Selects are registered here and the same flops feed the drive status byte
    nxt_st.head_side_bit      = head_req;
    nxt_st.drive_sel_high_bit = unit_req[1];
    nxt_st.drive_sel_low_bit  = unit_req[0];

    // Data port read: byte appears one cycle after the strobe
    nxt_st.rd_ok = rd_strobe;
    if (rd_strobe) begin
      case (rd_sel)
        REG_ONE:   nxt_st.rd_byte = err_one;
        REG_TWO:   nxt_st.rd_byte = err_two;
        REG_THREE: nxt_st.rd_byte = drive_lines;
        default:   nxt_st.rd_byte = STATUS_RST;
      endcase
    end
  end

  // Single state register for the block
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Pacer blocks steps until both the unit interval and cross-unit gap expire
  step_pacer u_pacer (
    .clk        (clk),
    .rstn       (rstn),
    .ms_tick    (st_ff.ms_tick),
    .step_req   (step_req),
    .step_unit  (unit_req),
    .step_rate  (step_rate),
    .half_rate  (half_rate),
    .step_grant (step_grant)
  );

  // Outputs straight from the state flops
  assign head_side  = st_ff.head_side_bit;
  assign drive_sel  = {st_ff.drive_sel_high_bit, st_ff.drive_sel_low_bit};
  assign step_pulse = st_ff.step_out;
  assign rd_data    = st_ff.rd_byte;
  assign rd_valid   = st_ff.rd_ok;

  // Checks on the flag and status paths
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic any_event;
  assign any_event = data_mark_miss | deleted_mark_seen | data_crc_err | sector_not_found |
                     scan_equal_hit | scan_no_match | id_check | id_search | st_ff.sync2[PIN_WP];

  a_nw_on_write: assert property (in_cmd && is_write_class(kind_now) && st_ff.sync2[PIN_WP]
                                  |=> st_ff.not_writable_flag)
    else $error("write protect missed during write-class command");
  a_index_twice: assert property (in_cmd && id_search && !id_found && idx_rise && st_ff.idx_count == 2'h1
                                  |=> st_ff.absent_header_flag)
    else $error("absent header not set after second index");
  a_mark_pair: assert property (in_cmd && data_mark_miss
                                |=> st_ff.absent_header_flag && st_ff.absent_data_flag)
    else $error("missing data mark did not set both flags");
  a_top_bit_zero: assert property (rd_strobe && rd_sel == REG_TWO |=> rd_valid && !rd_data[7])
    else $error("second error register top bit not zero");
  // A new command right after the error may clear the flag, so hold is only checked without one
  a_crc_flag: assert property (in_cmd && data_crc_err ##1 !cmd_start
    |-> st_ff.data_crc_flag ##1 st_ff.data_crc_flag)
    else $error("data crc flag not set or not held");
  a_bad_cyl: assert property (in_cmd && sector_not_found && is_sector_search(kind_now) &&
                              st_ff.cyl_mismatch && st_ff.cyl_all_ones
                              |=> st_ff.bad_cylinder_flag && st_ff.wrong_cylinder_flag)
    else $error("bad cylinder not flagged");
  a_fault_mirror: assert property (rd_strobe && rd_sel == REG_THREE
                                   |=> rd_data[ST3_FAULT] == $past(st_ff.sync2[PIN_FAULT]))
    else $error("fault bit does not follow pin");
  a_unit_mirror: assert property (rd_strobe && rd_sel == REG_THREE
                                  |=> rd_data[1:0] == $past(drive_sel))
    else $error("unit select bits do not follow outputs");
  a_start_clears: assert property (cmd_start && !any_event
                                   |=> {st_ff.no_sector_flag, st_ff.not_writable_flag, st_ff.absent_header_flag,
                                        st_ff.data_crc_flag, st_ff.scan_fail_flag} == 5'h00)
    else $error("flags not cleared at command start");
  a_scan_equal: assert property (in_cmd && kind_now == CMD_SCAN && scan_equal_hit
                                 |=> st_ff.scan_equal_flag)
    else $error("scan equal not flagged");

  // Remaining flag setters, each seen one cycle after its event, and the not-writable clear on a non-write start
  a_deleted_flag: assert property (in_cmd && deleted_mark_seen && is_read_or_scan(kind_now)
    |=> st_ff.deleted_record_flag)
    else $error("deleted record not flagged");
  a_wrong_cyl: assert property (in_cmd && sector_not_found && is_sector_search(kind_now)
    && st_ff.cyl_mismatch |=> st_ff.wrong_cylinder_flag)
    else $error("wrong cylinder not flagged");
  a_no_sector: assert property (in_cmd && sector_not_found && is_sector_search(kind_now)
    |=> st_ff.no_sector_flag)
    else $error("no-sector flag not set");
  a_scan_fail: assert property (in_cmd && kind_now == CMD_SCAN && scan_no_match
    |=> st_ff.scan_fail_flag)
    else $error("scan fail not flagged");
  a_absent_data: assert property (in_cmd && data_mark_miss
    |=> st_ff.absent_data_flag)
    else $error("absent data not flagged");
  a_nw_reads: assert property (cmd_start && !is_write_class(cmd_kind)
    |=> !st_ff.not_writable_flag)
    else $error("not-writable set outside write-class command");

  // Drive line bits of the status byte, against the flops they mirror
  a_track_zero: assert property (rd_strobe && rd_sel == REG_THREE
    |=> rd_data[ST3_TRACK_ZERO] == $past(st_ff.sync2[PIN_TRK0]))
    else $error("track zero bit does not follow pin");
  a_ready_mirror: assert property (rd_strobe && rd_sel == REG_THREE
    |=> rd_data[ST3_READY] == $past(st_ff.sync2[PIN_READY]))
    else $error("ready bit does not follow pin");
  a_head_mirror: assert property (rd_strobe && rd_sel == REG_THREE
    |=> rd_data[ST3_HEAD] == $past(head_side))
    else $error("head bit does not follow side select");

  c_write_protect: cover property (cmd_start && cmd_kind == CMD_WRITE ##[1:20] st_ff.not_writable_flag);
  c_no_sector:     cover property (st_ff.cyl_mismatch && sector_not_found ##1 st_ff.wrong_cylinder_flag);
  c_status_read:   cover property (rd_strobe && rd_sel == REG_THREE ##1 rd_valid);
  c_step_issued:   cover property (step_grant ##1 step_pulse);

endmodule

// >>> floppy_drive_model.sv
// Behavioural model of up to four drives on the status lines.
// Assumes drive_sel and step_pulse come straight from the block under test.
`timescale 1ns/100ps
module floppy_drive_model
#(
  parameter int IDX_PERIOD = 200,
  parameter int IDX_WIDTH  = 10
)
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [1:0]  drive_sel,
  input  wire logic        step_pulse,
  input  wire logic        spin,
  input  wire logic [15:0] cfg,
  output logic             fault_pin,
  output logic             write_protect_pin,
  output logic             ready_pin,
  output logic             track_zero_pin,
  output logic             two_side_pin,
  output logic             index_pin
);
  logic [1:0] cyl [4];
  logic [3:0] lines;
  logic       step_d;
  int         idx_cnt;

  // Only the selected unit answers; cfg packs fault, wp, ready, two-side per unit
  assign lines             = cfg[drive_sel*4 +: 4];
  assign fault_pin         = lines[3];
  assign write_protect_pin = lines[2];
  assign ready_pin         = lines[1];
  assign two_side_pin      = lines[0];
  assign track_zero_pin    = (cyl[drive_sel] == 2'h0);
  // Index only while spinning, so header searches can starve on purpose
  assign index_pin         = spin && (idx_cnt < IDX_WIDTH);

  // Each unit starts on its own cylinder and steps outward on each pulse until cylinder zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idx_cnt <= 0;
      step_d  <= 1'b0;
      for (int i = 0; i < 4; i++) cyl[i] <= 2'(i);
    end else begin
      idx_cnt <= (idx_cnt == IDX_PERIOD - 1) ? 0 : idx_cnt + 1;
      step_d  <= step_pulse;
      if (step_pulse && !step_d && cyl[drive_sel] != 2'h0) cyl[drive_sel] <= cyl[drive_sel] - 2'h1;
    end
  end
endmodule

// >>> tb.sv
// Self-checking bench for the result-status flag block.
// Assumes the drive model file; ms divider shortened to MSC cycles.
`timescale 1ns/100ps
module tb
  import disk_status_pkg::*;
;
  localparam int MSC = 400;
  logic       clk = 1'b0;
  logic       rstn, fault_pin, wp_pin, ready_pin, trk0_pin, two_pin, index_pin;
  logic       cmd_start, id_search, step_req, half_rate, rd_strobe, head_req, spin;
  logic       head_side, step_pulse, rd_valid;
  cmd_kind_t  cmd_kind;
  logic [6:0] ev;
  logic [7:0] cyl_read, target, rd_data;
  logic [3:0] step_rate;
  logic [1:0] rd_sel, unit_req, drive_sel;
  logic [15:0] cfg;
  int         err_total, n_tests, cyc;

  always #50 clk = ~clk;
  always @(posedge clk) cyc++;

  disk_ctrl_result_status_flags #(.MS_CYCLES(MSC)) uut (.clk(clk), .rstn(rstn), .fault_pin(fault_pin),
    .write_protect_pin(wp_pin), .ready_pin(ready_pin), .track_zero_pin(trk0_pin), .two_side_pin(two_pin),
    .index_pin(index_pin), .cmd_start(cmd_start), .cmd_kind(cmd_kind), .cmd_done(1'b0),
    .id_search(id_search), .id_found(1'b0), .id_check(ev[6]), .cyl_read(cyl_read),
    .target_id_fields(target), .data_mark_miss(ev[0]), .deleted_mark_seen(ev[1]), .data_crc_err(ev[2]),
    .sector_not_found(ev[3]), .scan_equal_hit(ev[4]), .scan_no_match(ev[5]), .head_req(head_req),
    .unit_req(unit_req), .step_req(step_req), .step_rate(step_rate), .half_rate(half_rate),
    .rd_strobe(rd_strobe), .rd_sel(rd_sel), .head_side(head_side), .drive_sel(drive_sel),
    .step_pulse(step_pulse), .rd_data(rd_data), .rd_valid(rd_valid));

  floppy_drive_model drv (.clk(clk), .rstn(rstn), .drive_sel(drive_sel), .step_pulse(step_pulse),
    .spin(spin), .cfg(cfg), .fault_pin(fault_pin), .write_protect_pin(wp_pin), .ready_pin(ready_pin),
    .track_zero_pin(trk0_pin), .two_side_pin(two_pin), .index_pin(index_pin));

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask

  // One register read; answer expected exactly one cycle after the strobe
  task automatic rd(input logic [1:0] sel, output logic [7:0] d);
    @(negedge clk);
    rd_strobe = 1'b1;
    rd_sel = sel;
    @(negedge clk);
    rd_strobe = 1'b0;
    chk({7'h00, rd_valid}, 8'h01);
    d = rd_data;
  endtask

  task automatic rd12(input logic [7:0] e1, input logic [7:0] e2);
    logic [7:0] d;
    rd(REG_ONE, d);
    chk(d, e1);
    rd(REG_TWO, d);
    chk(d, e2);
  endtask

  task automatic start(input cmd_kind_t k);
    @(negedge clk);
    cmd_kind = k;
    cmd_start = 1'b1;
    @(negedge clk);
    cmd_start = 1'b0;
  endtask

  task automatic pulse(input logic [6:0] e);
    @(negedge clk);
    ev = e;
    @(negedge clk);
    ev = 7'h00;
  endtask

  task automatic t_drive();
    logic [7:0] d;
    logic [3:0] c;
    for (int u = 0; u < 4; u++) begin
      unit_req = 2'(u);
      head_req = ~unit_req[0];
      repeat (4) @(negedge clk);
      c = cfg[u*4 +: 4];
      rd(REG_THREE, d);
      chk(d, {c[3:1], u == 0, c[0], ~unit_req[0], unit_req});
    end
    $display("drive status test done");
  endtask

  // Unit 0 is write protected; only write-class commands may report it
  task automatic t_wp();
    unit_req = 2'h0;
    start(CMD_WRITE);
    repeat (4) @(negedge clk);
    rd12(8'h02, 8'h00);
    start(CMD_READ);
    repeat (4) @(negedge clk);
    rd12(8'h00, 8'h00);
    $display("write protect test done");
  endtask

  // Each event but id_check alone in a fresh scan command; the restart must wipe the last one
  task automatic t_flags();
    logic [7:0] e1 [6] = '{8'h01, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00};
    logic [7:0] e2 [6] = '{8'h01, 8'h40, 8'h20, 8'h00, 8'h08, 8'h04};
    for (int i = 0; i < 6; i++) begin
      start(CMD_SCAN);
      pulse(7'(1 << i));
      rd12(e1[i], e2[i]);
    end
    start(CMD_WRITE);
    pulse(7'h02);
    rd12(8'h02, 8'h00);
    $display("flag table test done");
  endtask

  task automatic t_cyl();
    target = 8'h03;
    cyl_read = 8'hff;
    start(CMD_READ);
    pulse(7'h40);
    pulse(7'h08);
    rd12(8'h04, 8'h12);
    cyl_read = 8'h05;
    start(CMD_READ);
    pulse(7'h40);
    pulse(7'h08);
    rd12(8'h04, 8'h10);
    $display("cylinder test done");
  endtask

  task automatic t_index();
    logic [7:0] d;
    int k;
    start(CMD_READ);
    id_search = 1'b1;
    spin = 1'b1;
    d = 8'h00;
    k = 0;
    while (d[0] !== 1'b1 && k < 400) begin
      rd(REG_ONE, d);
      k++;
    end
    chk(d, 8'h01);
    chk(8'(k > 60), 8'h01);
    if (k == 400) report_and_stop();
    id_search = 1'b0;
    spin = 1'b0;
    $display("index test done");
  endtask

  task automatic step(input logic [1:0] u, output int t);
    int k;
    logic prev;
    k = 0;
    @(negedge clk);
    unit_req = u;
    step_req = 1'b1;
    prev = 1'b1;
    // Wait for a fresh rise; the previous step's pulse may still be high here
    while (!(step_pulse === 1'b1 && prev === 1'b0) && k < 5000) begin
      prev = step_pulse;
      @(negedge clk);
      k++;
    end
    if (k == 5000) begin
      err_total++;
      report_and_stop();
    end
    t = cyc;
    step_req = 1'b0;
  endtask

  task automatic win(input int d, input int lo, input int hi);
    chk(8'(d >= lo && d <= hi), 8'h01);
  endtask

  task automatic t_step();
    int t0, t1, t2;
    step_rate = 4'he;
    step(2'h0, t0);
    step(2'h1, t1);
    win(t1 - t0, 330, 340);
    step(2'h1, t2);
    win(t2 - t1, 2 * MSC, 3 * MSC + 10);
    half_rate = 1'b1;
    step_rate = 4'hf;
    step(2'h2, t0);
    step(2'h3, t1);
    win(t1 - t0, 660, 670);
    step(2'h3, t2);
    win(t2 - t1, 2 * MSC, 4 * MSC + 10);
    $display("step pacing test done");
  endtask

  initial begin
    {rstn, cmd_start, id_search, step_req, half_rate, rd_strobe, head_req, spin} = 8'h00;
    {ev, cyl_read, target, step_rate, rd_sel, unit_req} = '0;
    cmd_kind = CMD_OTHER;
    cfg = 16'hd3a4;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    t_drive();
    t_wp();
    t_flags();
    t_cyl();
    t_index();
    t_step();
    report_and_stop();
  end
endmodule
